// ---- src/tmr_defs.svh ----
// Constants for the eight-bit dual compare timer: limits, mode and select codes.
// Assumes inclusion by the timer module only; the package does not include it.
// How it works
// - Counter and both compare values are eight bits; one up/down counting unit.
// - Counter value zero is bottom; a bottom indication is raised on at_bottom_out.
// - Counter value 255 is max.
// - Top is 255 or compare value A, chosen by waveform mode.
// - Timer clock is the I/O clock unless async select picks the crystal.
// - Clock select zero gives no timer clock; the counter halts.
// - CPU may always read and write the counter; writes beat clear and count.
// - Each timer clock clears, increments or decrements the counter per mode.
// - A three-bit waveform mode field selects the counting sequence.
// - Overflow flag is set where the mode says and may request interrupt.
// - Equal counter and compare value sets that compare flag next timer clock.
// - Compare flags clear on interrupt execution or on writing one.
// - All three flags are visible; each requests only when its mask is set.
// - PWM modes double buffer compare values, updating at top; others bypass.
// - CPU compare accesses reach the buffer when buffering, else the active copy.
// - Force strobe in non-PWM modes acts like a match without flag or clear.
// - Two-bit output action sets, clears or toggles; changes act at once.
// - A counter write blocks all compare matches in the next timer clock.
// - Compare output state holds across waveform mode changes.
// - The timer runs only while the timer power bit is one.
// - Normal mode counts up, wraps 255 to zero, sets overflow at zero.
// - Clear-on-match mode clears the counter when it equals compare value A.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_BOTTOM     8'h00
`define TMR_MAX        8'hFF
`define TMR_MODE_NORM  3'h0
`define TMR_MODE_PC_FF 3'h1
`define TMR_MODE_CTC   3'h2
`define TMR_MODE_FP_FF 3'h3
`define TMR_MODE_PC_A  3'h5
`define TMR_MODE_FP_A  3'h7
`define TMR_CS_STOP    3'h0
`define TMR_CS_DIV8    3'h2
`define TMR_CS_DIV32   3'h3
`define TMR_CS_DIV64   3'h4
`define TMR_CS_DIV128  3'h5
`define TMR_CS_DIV256  3'h6
`define TMR_CS_DIV1024 3'h7
`define TMR_COM_NONE   2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR  2'h2
`define TMR_COM_SET    2'h3
`define TMR_PRE_W      10
`define TMR_MSK_8      10'h007
`define TMR_MSK_32     10'h01F
`define TMR_MSK_64     10'h03F
`define TMR_MSK_128    10'h07F
`define TMR_MSK_256    10'h0FF
`define TMR_MSK_1024   10'h3FF
`define TMR_FLG_OVF    0
`define TMR_FLG_CMPA   1
`define TMR_FLG_CMPB   2
`endif

// ---- src/tmr_pkg.sv ----
// Types shared by the timer: control bundle and count direction.
// Assumes the constants header sits beside it.
package tmr_pkg;
  typedef struct packed {
    logic       timer_power_bit;
    logic       async_clock_select;
    logic [2:0] clock_select_field;
    logic [2:0] waveform_mode_field;
    logic [1:0] compare_output_action_a;
    logic [1:0] compare_output_action_b;
  } tmr_ctrl_s;

  typedef enum logic {
    TMR_DIR_UP   = 1'b0,
    TMR_DIR_DOWN = 1'b1
  } tmr_dir_e;
endpackage : tmr_pkg

// ---- src/tmr_timer8.sv ----
// Eight-bit timer with two compare channels, prescaler and crystal clock option.
// Assumes control and CPU strobes come from logic on clk_in; crystal pin is async.
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_timer8
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  // Crystal oscillator pin, asynchronous
  input  wire logic      crystal_pin_one_in,
  // Control fields
  input  wire tmr_ctrl_s ctrl_in,
  input  wire logic [2:0] timer_mask_register_in,
  // Counter and compare writes
  input  wire logic      cnt_wr_in,
  input  wire logic [7:0] cnt_wdata_in,
  input  wire logic      cmp_a_wr_in,
  input  wire logic      cmp_b_wr_in,
  input  wire logic [7:0] cmp_wdata_in,
  input  wire logic      force_compare_strobe_a_in,
  input  wire logic      force_compare_strobe_b_in,
  // Flag clears: write-one and interrupt execution
  input  wire logic [2:0] flag_clr_in,
  input  wire logic [2:0] int_ack_in,
  // Status and outputs
  output logic [7:0]     counter_value_out,
  output logic [7:0]     compare_value_a_out,
  output logic [7:0]     compare_value_b_out,
  output logic [2:0]     timer_flag_register_out,
  output logic [2:0]     irq_out,
  output logic           at_bottom_out,
  output logic           compare_output_a_out,
  output logic           compare_output_b_out
);

  // Prescaler tap mask for a clock select code; stop gives no tick at all
  function automatic logic [`TMR_PRE_W-1:0] tap_mask(input logic [2:0] cs);
    case (cs)
      `TMR_CS_DIV8:    tap_mask = `TMR_MSK_8;
      `TMR_CS_DIV32:   tap_mask = `TMR_MSK_32;
      `TMR_CS_DIV64:   tap_mask = `TMR_MSK_64;
      `TMR_CS_DIV128:  tap_mask = `TMR_MSK_128;
      `TMR_CS_DIV256:  tap_mask = `TMR_MSK_256;
      `TMR_CS_DIV1024: tap_mask = `TMR_MSK_1024;
      default: tap_mask = '0;
    endcase
  endfunction : tap_mask

  // Output action on a non-PWM match or force
  function automatic logic act(input logic [1:0] com, input logic cur);
    case (com)
      `TMR_COM_TOGGLE: act = ~cur;
      `TMR_COM_CLEAR:  act = 1'b0;
      `TMR_COM_SET:    act = 1'b1;
      default:         act = cur;
    endcase
  endfunction : act

  // PWM output: match drives one level, the other event the opposite
  function automatic logic pwm_out(input logic [1:0] com, input logic cur,
                                   input logic mt, input logic lvl, input logic ev);
    if ((com != `TMR_COM_CLEAR && com != `TMR_COM_SET) || !(mt || ev))
      pwm_out = cur;
    else
      pwm_out = (mt ? lvl : ~lvl) ^ (com == `TMR_COM_SET);
  endfunction : pwm_out

  // Reset release through two flip-flops
  logic rst_s1_q, rst_n;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  default clocking cb_chk @(posedge clk_in); endclocking // Checks run on the system clock
  default disable iff (!rst_n); // Checks sleep while the internal reset is low

  // Crystal pin synchroniser; only stages two and three feed logic, stage three as edge history
  logic xt_s1_q, xt_s2_q, xt_s3_q;

  // State
  logic [7:0]           cnt_q, cnt_d, ocra_q, ocra_d, ocrb_q, ocrb_d;
  logic [7:0]           bufa_q, bufa_d, bufb_q, bufb_d;
  logic [`TMR_PRE_W-1:0] pre_q, pre_d;
  logic [2:0]           flg_q, flg_d, irq_d;
  logic                 blk_q, blk_d, oca_q, oca_d, ocb_q, ocb_d, bot_q, bot_d;
  logic [7:0]           vwa_q, vwa_d, vwb_q, vwb_d;
  tmr_dir_e             dir_q, dir_d;

  // Decoded mode, clock and events
  logic [2:0] mode;
  logic [7:0] top;
  logic base, tick, pwm, pc, fast, at_top, mt_a, mt_b, ovf, upd, frc_a, frc_b;

  always_comb
  begin
    mode = ctrl_in.waveform_mode_field;
    pc   = (mode == `TMR_MODE_PC_FF) || (mode == `TMR_MODE_PC_A);
    fast = (mode == `TMR_MODE_FP_FF) || (mode == `TMR_MODE_FP_A);
    pwm  = pc || fast;
    // Top is A in CTC and in the modes that name it; else the fixed max
    top  = (mode == `TMR_MODE_CTC || mode == `TMR_MODE_PC_A || mode == `TMR_MODE_FP_A)
           ? ocra_q : `TMR_MAX;
    // Crystal rising edge or every I/O clock feeds the prescaler
    base = ctrl_in.async_clock_select ? (xt_s2_q & ~xt_s3_q) : 1'b1;
    tick = ctrl_in.timer_power_bit && base
           && (ctrl_in.clock_select_field != `TMR_CS_STOP)
           && ((pre_q & tap_mask(ctrl_in.clock_select_field))
               == tap_mask(ctrl_in.clock_select_field));
    at_top = (cnt_q == top);
    // Blocked for one timer clock after a counter write
    mt_a = tick && !blk_q && (cnt_q == ocra_q);
    mt_b = tick && !blk_q && (cnt_q == ocrb_q);
    ovf  = tick && (pc ? (cnt_q == `TMR_BOTTOM)
                       : (cnt_q == (fast ? top : `TMR_MAX)));
    upd   = tick && pwm && at_top;
    frc_a = force_compare_strobe_a_in && !pwm;
    frc_b = force_compare_strobe_b_in && !pwm;
  end

  // Counter, direction, prescaler and write blocking next values
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    pre_d = base ? pre_q + 1'b1 : pre_q;
    blk_d = blk_q;
    if (tick)
    begin
      blk_d = 1'b0;
      if (pc)
      begin
        if (dir_q == TMR_DIR_UP && at_top)
        begin
          dir_d = TMR_DIR_DOWN;
          cnt_d = cnt_q - 1'b1;
        end
        else if (dir_q == TMR_DIR_DOWN && cnt_q == `TMR_BOTTOM)
        begin
          dir_d = TMR_DIR_UP;
          cnt_d = cnt_q + 1'b1;
        end
        else
          cnt_d = (dir_q == TMR_DIR_UP) ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
      else
      begin
        dir_d = TMR_DIR_UP;
        cnt_d = at_top ? `TMR_BOTTOM : cnt_q + 1'b1;
      end
    end
    // CPU write wins over clear and count, and arms the block
    if (cnt_wr_in)
    begin
      cnt_d = cnt_wdata_in;
      blk_d = 1'b1;
    end
    bot_d = (cnt_d == `TMR_BOTTOM); // Flopped so the pin never glitches
  end

  // Compare registers: buffered copy in PWM modes, direct otherwise
  always_comb
  begin
    bufa_d = bufa_q;
    bufb_d = bufb_q;
    ocra_d = ocra_q;
    ocrb_d = ocrb_q;
    if (cmp_a_wr_in)
    begin
      bufa_d = cmp_wdata_in;
      if (!pwm)
        ocra_d = cmp_wdata_in;
    end
    if (cmp_b_wr_in)
    begin
      bufb_d = cmp_wdata_in;
      if (!pwm)
        ocrb_d = cmp_wdata_in;
    end
    if (upd)
    begin
      ocra_d = bufa_q;
      ocrb_d = bufb_q;
    end
    vwa_d = pwm ? bufa_d : ocra_d; // Readback of the copy the CPU reaches
    vwb_d = pwm ? bufb_d : ocrb_d;
  end

  // Flags: a set in the same cycle as a clear is kept
  always_comb
  begin
    flg_d = flg_q & ~(flag_clr_in | int_ack_in);
    flg_d[`TMR_FLG_OVF]  = flg_d[`TMR_FLG_OVF] | ovf;
    flg_d[`TMR_FLG_CMPA] = flg_d[`TMR_FLG_CMPA] | mt_a;
    flg_d[`TMR_FLG_CMPB] = flg_d[`TMR_FLG_CMPB] | mt_b;
    irq_d = flg_d & timer_mask_register_in;
  end

  // Compare outputs; state is never reset by a mode change
  always_comb
  begin
    oca_d = oca_q;
    ocb_d = ocb_q;
    if (!pwm)
    begin
      if (mt_a || frc_a)
        oca_d = act(ctrl_in.compare_output_action_a, oca_q);
      if (mt_b || frc_b)
        ocb_d = act(ctrl_in.compare_output_action_b, ocb_q);
    end
    else if (fast)
    begin
      if (mode == `TMR_MODE_FP_A && mt_a
          && ctrl_in.compare_output_action_a == `TMR_COM_TOGGLE)
        oca_d = ~oca_q;
      else
        oca_d = pwm_out(ctrl_in.compare_output_action_a, oca_q, mt_a, 1'b0,
                        upd);
      ocb_d = pwm_out(ctrl_in.compare_output_action_b, ocb_q, mt_b, 1'b0, upd);
    end
    else
    begin
      // Phase correct, clear action: up-count match clears, down-count match sets; the set action inverts both
      oca_d = pwm_out(ctrl_in.compare_output_action_a, oca_q,
                      mt_a && dir_q == TMR_DIR_UP, 1'b0,
                      mt_a && dir_q == TMR_DIR_DOWN);
      ocb_d = pwm_out(ctrl_in.compare_output_action_b, ocb_q,
                      mt_b && dir_q == TMR_DIR_UP, 1'b0,
                      mt_b && dir_q == TMR_DIR_DOWN);
    end
  end

  // Register all state; reset zeroes everything except the bottom indication, which starts at one
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= `TMR_BOTTOM;
      ocra_q <= `TMR_BOTTOM;
      ocrb_q <= `TMR_BOTTOM;
      bufa_q <= `TMR_BOTTOM;
      bufb_q <= `TMR_BOTTOM;
      pre_q  <= '0;
      flg_q  <= '0;
      irq_out <= '0;
      blk_q  <= 1'b0;
      oca_q  <= 1'b0;
      ocb_q  <= 1'b0;
      dir_q  <= TMR_DIR_UP;
      vwa_q  <= `TMR_BOTTOM;
      vwb_q  <= `TMR_BOTTOM;
      bot_q  <= 1'b1;
      xt_s1_q <= 1'b0;
      xt_s2_q <= 1'b0;
      xt_s3_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      ocra_q <= ocra_d;
      ocrb_q <= ocrb_d;
      bufa_q <= bufa_d;
      bufb_q <= bufb_d;
      pre_q  <= pre_d;
      flg_q  <= flg_d;
      irq_out <= irq_d;
      blk_q  <= blk_d;
      oca_q  <= oca_d;
      ocb_q  <= ocb_d;
      dir_q  <= dir_d;
      vwa_q  <= vwa_d;
      vwb_q  <= vwb_d;
      bot_q  <= bot_d;
      xt_s1_q <= crystal_pin_one_in;
      xt_s2_q <= xt_s1_q;
      xt_s3_q <= xt_s2_q;
    end
  end

  // Visible state; buffered reads follow the copy the CPU reaches
  assign counter_value_out       = cnt_q;
  assign compare_value_a_out     = vwa_q;
  assign compare_value_b_out     = vwb_q;
  assign timer_flag_register_out = flg_q;
  assign at_bottom_out           = bot_q;
  assign compare_output_a_out    = oca_q;
  assign compare_output_b_out    = ocb_q;

  // Checks
  property p_halt;
    (ctrl_in.clock_select_field == `TMR_CS_STOP && !cnt_wr_in) |=> $stable(cnt_q);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");
  property p_wr;
    cnt_wr_in |=> (cnt_q == $past(cnt_wdata_in));
  endproperty
  a_wr: assert property (p_wr) else $error("counter write lost");
  property p_wrap;
    (mode == `TMR_MODE_NORM && tick && cnt_q == `TMR_MAX && !cnt_wr_in)
      |=> (cnt_q == `TMR_BOTTOM) && flg_q[`TMR_FLG_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("normal wrap wrong");
  property p_ctc;
    (mode == `TMR_MODE_CTC && tick && cnt_q == ocra_q && !cnt_wr_in)
      |=> cnt_q == `TMR_BOTTOM;
  endproperty
  a_ctc: assert property (p_ctc) else $error("clear on match missed");
  property p_blk;
    $rose(flg_q[`TMR_FLG_CMPA]) |-> !$past(blk_q);
  endproperty
  a_blk: assert property (p_blk) else $error("blocked match set flag");
  property p_flag;
    (tick && !blk_q && cnt_q == ocrb_q) |=> flg_q[`TMR_FLG_CMPB];
  endproperty
  a_flag: assert property (p_flag) else $error("compare flag not set");
  property p_force;
    (frc_a && !mt_a && ctrl_in.compare_output_action_a == `TMR_COM_TOGGLE)
      |=> (oca_q != $past(oca_q)) && ($past(flg_q[`TMR_FLG_CMPA]) || !flg_q[`TMR_FLG_CMPA]);
  endproperty
  a_force: assert property (p_force) else $error("force strobe wrong");
  property p_irq;
    ##1 (irq_out == (flg_q & $past(timer_mask_register_in)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not masked flag");
endmodule : tmr_timer8

// ---- tb/tb_top.sv ----
// Self-checking bench for the eight-bit dual compare timer, one task per scenario.
// Assumes the timer package and module are compiled first; the bench drives every port.
`timescale 1ns/1ps

module tb_top;
  import tmr_pkg::*;

  // Stimulus, driven at the falling edge
  logic       clk      = 1'b0;
  logic       rst_n    = 1'b0;
  logic       xtal     = 1'b0;
  tmr_ctrl_s  ctrl     = '0;
  logic [2:0] mask     = 3'h0;
  logic       cnt_wr   = 1'b0;
  logic [7:0] cnt_wd   = 8'h00;
  logic       cmp_a_wr = 1'b0;
  logic       cmp_b_wr = 1'b0;
  logic [7:0] cmp_wd   = 8'h00;
  logic       foc_a    = 1'b0;
  logic       foc_b    = 1'b0;
  logic [2:0] clr      = 3'h0;
  logic [2:0] ack      = 3'h0;
  // Observed outputs
  logic [7:0] cnt;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic [2:0] flags;
  logic [2:0] irq;
  logic       bottom;
  logic       oc_a;
  logic       oc_b;
  int         n_fail   = 0;
  int         checks   = 0;

  tmr_timer8 dut (
    .clk_in(clk), .rst_n_in(rst_n), .crystal_pin_one_in(xtal), .ctrl_in(ctrl),
    .timer_mask_register_in(mask), .cnt_wr_in(cnt_wr), .cnt_wdata_in(cnt_wd),
    .cmp_a_wr_in(cmp_a_wr), .cmp_b_wr_in(cmp_b_wr), .cmp_wdata_in(cmp_wd),
    .force_compare_strobe_a_in(foc_a), .force_compare_strobe_b_in(foc_b),
    .flag_clr_in(clr), .int_ack_in(ack), .counter_value_out(cnt),
    .compare_value_a_out(cmp_a), .compare_value_b_out(cmp_b),
    .timer_flag_register_out(flags), .irq_out(irq), .at_bottom_out(bottom),
    .compare_output_a_out(oc_a), .compare_output_b_out(oc_b)
  );

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Clock select 0 stops the timer; power stays on so the select alone decides
  task automatic run(input logic [2:0] cs);
    ctrl.timer_power_bit    = 1'b1;
    ctrl.clock_select_field = cs;
  endtask : run

  task automatic wr_cnt(input logic [7:0] v);
    tick(1);
    cnt_wr = 1'b1;
    cnt_wd = v;
    tick(1);
    cnt_wr = 1'b0;
  endtask : wr_cnt

  task automatic wr_cmp(input bit b, input logic [7:0] v);
    tick(1);
    cmp_a_wr = ~b;
    cmp_b_wr = b;
    cmp_wd   = v;
    tick(1);
    cmp_a_wr = 1'b0;
    cmp_b_wr = 1'b0;
  endtask : wr_cmp

  task automatic pulse(input logic [2:0] c, input logic [2:0] a);
    tick(1);
    clr = c;
    ack = a;
    tick(1);
    clr = 3'h0;
    ack = 3'h0;
    tick(1);
  endtask : pulse

  // Bounded wait for one flag; running out ends the run as a failure
  task automatic wait_flag(input int b, input int lim);
    int i;
    for (i = 0; i < lim && flags[b] !== 1'b1; i++)
      tick(1);
    if (i == lim)
    begin
      chk("flag wait", {5'h00, flags}, 8'h07);
      tally_and_finish();
    end
  endtask : wait_flag

  task automatic s_reset;
    chk("counter", cnt, 8'h00);
    chk("compares", cmp_a | cmp_b, 8'h00);
    chk("flags irq", {2'h0, flags, irq}, 8'h00);
    chk("bottom outs", {5'h00, bottom, oc_b, oc_a}, 8'h04);
  endtask : s_reset

  task automatic s_stop;
    wr_cnt(8'h37);
    chk("counter write", cnt, 8'h37);
    chk("bottom", {7'h00, bottom}, 8'h00);
    run(3'h0);
    tick(20);
    chk("halted", cnt, 8'h37);
    ctrl.clock_select_field = 3'h1;
    ctrl.timer_power_bit    = 1'b0;
    tick(20);
    chk("power off", cnt, 8'h37);
    run(3'h0);
  endtask : s_stop

  task automatic s_overflow;
    mask = 3'b001;
    wr_cnt(8'hFD);
    pulse(3'h7, 3'h0);
    run(3'h1);
    wait_flag(0, 10);
    run(3'h0);
    chk("ovf irq", {7'h00, irq[0]}, 8'h01);
    chk("wrap", cnt, 8'h00);
    pulse(3'h0, 3'h1);
    chk("ovf ack", {6'h00, irq[0], flags[0]}, 8'h00);
  endtask : s_overflow

  task automatic s_match;
    wr_cmp(1'b0, 8'h10);
    wr_cmp(1'b1, 8'h12);
    mask = 3'b010;
    wr_cnt(8'h0C);
    pulse(3'h7, 3'h0);
    run(3'h1);
    wait_flag(1, 10);
    chk("irq a", {7'h00, irq[1]}, 8'h01);
    wait_flag(2, 6);
    run(3'h0);
    chk("irq b masked", {7'h00, irq[2]}, 8'h00);
    pulse(3'b010, 3'h0);
    chk("clear a", {5'h00, flags[2:1], 1'b0}, 8'h04);
    pulse(3'h0, 3'b100);
    chk("ack b", {5'h00, flags[2:1], 1'b0}, 8'h00);
  endtask : s_match

  task automatic s_block;
    wr_cmp(1'b1, 8'h40);
    wr_cnt(8'h40);
    tick(3);
    run(3'h1);
    tick(4);
    run(3'h0);
    tick(2);
    chk("blocked b", {7'h00, flags[2]}, 8'h00);
  endtask : s_block

  task automatic s_ctc;
    logic [7:0] hi;
    hi = 8'h00;
    ctrl.waveform_mode_field = 3'h2;
    wr_cmp(1'b0, 8'h05);
    wr_cnt(8'h00);
    run(3'h1);
    repeat (30)
    begin
      tick(1);
      if (cnt > hi)
        hi = cnt;
    end
    run(3'h0);
    chk("ctc top", hi, 8'h05);
  endtask : s_ctc

  task automatic s_force;
    logic [1:0] act [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    ctrl.waveform_mode_field = 3'h0;
    wr_cnt(8'h80);
    pulse(3'h7, 3'h0);
    for (int i = 0; i < 4; i++)
    begin
      ctrl.compare_output_action_a = act[i];
      ctrl.compare_output_action_b = act[i];
      foc_a = 1'b1;
      foc_b = 1'b1;
      tick(1);
      foc_a = 1'b0;
      foc_b = 1'b0;
      tick(1);
      chk("forced out", {6'h00, oc_b, oc_a}, {6'h00, exp[i], exp[i]});
    end
    chk("force side", {cnt[7:2], flags[2:1]}, 8'h80);
    ctrl.waveform_mode_field     = 3'h3;
    ctrl.compare_output_action_a = 2'h2;
    foc_a = 1'b1;
    tick(1);
    foc_a = 1'b0;
    tick(1);
    chk("mode change", {6'h00, oc_b, oc_a}, 8'h03);
  endtask : s_force

  task automatic s_dbuf;
    ctrl.waveform_mode_field = 3'h0;
    wr_cmp(1'b0, 8'h10);
    ctrl.waveform_mode_field = 3'h3;
    wr_cmp(1'b0, 8'h30);
    chk("buffer view", cmp_a, 8'h30);
    wr_cnt(8'h20);
    pulse(3'h7, 3'h0);
    run(3'h1);
    tick(24);
    chk("old active", {7'h00, flags[1]}, 8'h00);
    wait_flag(1, 300);
    run(3'h0);
    chk("new active", cnt, 8'h31);
  endtask : s_dbuf

  task automatic s_xtal;
    ctrl.waveform_mode_field = 3'h0;
    wr_cnt(8'h00);
    ctrl.async_clock_select = 1'b1;
    run(3'h1);
    tick(10);
    chk("crystal idle", cnt, 8'h00);
    repeat (4)
    begin
      xtal = 1'b1;
      tick(3);
      xtal = 1'b0;
      tick(3);
    end
    tick(4);
    chk("crystal count", cnt, 8'h04);
    run(3'h0);
    ctrl.async_clock_select = 1'b0;
  endtask : s_xtal

  // Phase correct with top from compare A: up to top, then down; up match clears, down sets
  task automatic s_phase;
    ctrl.waveform_mode_field = 3'h0;
    wr_cmp(1'b0, 8'h06);
    wr_cmp(1'b1, 8'h05);
    chk("compare b", cmp_b, 8'h05);
    // Outputs are preset by force in normal mode before any PWM use
    ctrl.compare_output_action_a = 2'h3;
    ctrl.compare_output_action_b = 2'h3;
    foc_a = 1'b1;
    foc_b = 1'b1;
    tick(1);
    foc_a = 1'b0;
    foc_b = 1'b0;
    ctrl.compare_output_action_a = 2'h2;
    ctrl.compare_output_action_b = 2'h2;
    ctrl.waveform_mode_field     = 3'h5;
    wr_cnt(8'h04);
    run(3'h1);
    tick(2);
    chk("pc top", cnt, 8'h06);
    chk("pc up outs", {6'h00, oc_b, oc_a}, 8'h01);
    tick(2);
    run(3'h0);
    chk("pc down", cnt, 8'h04);
    chk("pc down outs", {6'h00, oc_b, oc_a}, 8'h02);
  endtask : s_phase

  // Main sequence: reset for three cycles, then every scenario
  initial
  begin
    tick(3);
    rst_n = 1'b1;
    tick(3);
    s_reset();
    s_stop();
    s_overflow();
    s_match();
    s_block();
    s_ctc();
    s_force();
    s_dbuf();
    s_xtal();
    s_phase();
    tally_and_finish();
  end
endmodule : tb_top
